// ===== logic/uar_consts.vh
// constants for the asynchronous receive recovery block
`ifndef UAR_CONSTS_VH
`define UAR_CONSTS_VH

// samples per bit period
`define UAR_SPB_NORM 5'h10
`define UAR_SPB_DBL 5'h08
// first of the three voting samples
`define UAR_VOTE_FIRST_NORM 5'h08
`define UAR_VOTE_FIRST_DBL 5'h04
// voting window is first .. first + 2
`define UAR_VOTE_SPAN 5'h02
// samples a double-speed receiver waits after stop voting
`define UAR_DBL_DEFER 3'h2
// reset values
`define UAR_PHASE_RST 5'h00
`define UAR_BITCNT_RST 4'h0
`define UAR_VOTE_RST 3'h7
// frame length limits (data plus parity)
`define UAR_FRAME_BITS_MIN 4'h5
`define UAR_FRAME_BITS_MAX 4'hA

`endif

// ===== logic/uar_fifo.v
// shift-style fifo for received frames, outputs held in flip-flops
`timescale 1ns/1ps
`include "uar_consts.vh"

module uar_fifo #(
   parameter WIDTH = 11,
   parameter DEPTH = 4,
   parameter CNT_W = 3
) (
   input wire i_core_clk,
   input wire i_sys_rst,
   input wire i_in_valid,
   input wire [WIDTH-1:0] i_in_data,
   output reg o_in_ready,
   output reg o_out_valid,
   output wire [WIDTH-1:0] o_out_data,
   input wire i_out_ready
);

   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [CNT_W-1:0] cnt_r;
   reg [CNT_W-1:0] cnt_nxt;
   wire push;
   wire pop;
   integer i;

   assign push = i_in_valid & o_in_ready;
   assign pop = i_out_ready & o_out_valid;
   // head entry is a flip-flop, so the reader sees registered data
   assign o_out_data = mem_r[0];

   always @* begin
      cnt_nxt = cnt_r;
      if (push & ~pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop & ~push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         cnt_r <= {CNT_W{1'b0}};
         o_in_ready <= 1'b1;
         o_out_valid <= 1'b0;
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_r[i] <= {WIDTH{1'b0}};
         end
      end else begin
         cnt_r <= cnt_nxt;
         o_in_ready <= (cnt_nxt != DEPTH[CNT_W-1:0]);
         o_out_valid <= (cnt_nxt != {CNT_W{1'b0}});
         for (i = 0; i < DEPTH; i = i + 1) begin
            if (pop && (i < DEPTH - 1)) begin
               mem_r[i] <= mem_r[i+1];
            end
            if (push && (i == cnt_r - (pop ? 1 : 0))) begin
               mem_r[i] <= i_in_data;
            end
         end
      end
   end

endmodule

// ===== logic/uar_rx_recovery.v
// asynchronous receive clock and data recovery with frame fifo
`timescale 1ns/1ps
`include "uar_consts.vh"

module uar_rx_recovery #(
   parameter MAX_BITS = 10,
   parameter FIFO_DEPTH = 4,
   parameter FIFO_CNT_W = 3
) (
   input wire i_core_clk,
   input wire i_sys_rst,
   input wire i_rx_serial_in,
   input wire i_os_tick,
   input wire i_double_speed_sel,
   input wire [3:0] i_frame_bits,
   input wire i_rx_ready,
   output wire o_rx_valid,
   output wire [MAX_BITS-1:0] o_rx_data,
   output wire o_frame_error_flag,
   output reg o_rx_overrun,
   output reg o_rx_busy
);

   // ---------------------------------------------------------------
   // states
   // ---------------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_START = 3'h1;
   localparam [2:0] ST_DATA = 3'h2;
   localparam [2:0] ST_STOP = 3'h3;
   localparam [2:0] ST_DEFER = 3'h4;

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   function maj3;
      input [2:0] v;
      begin
         maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
      end
   endfunction

   // exact 16x or 8x sample count, no fractional baud error added here
   function [4:0] spb;
      input dbl;
      begin
         spb = dbl ? `UAR_SPB_DBL : `UAR_SPB_NORM;
      end
   endfunction

   function [4:0] vote_first;
      input dbl;
      begin
         vote_first = dbl ? `UAR_VOTE_FIRST_DBL : `UAR_VOTE_FIRST_NORM;
      end
   endfunction

   // ---------------------------------------------------------------
   // line synchroniser
   // ---------------------------------------------------------------
   reg rx_meta_r;
   reg rx_sync_r;

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         rx_meta_r <= 1'b1;
         rx_sync_r <= 1'b1;
      end else begin
         rx_meta_r <= i_rx_serial_in;
         rx_sync_r <= rx_meta_r;
      end
   end

   // ---------------------------------------------------------------
   // recovery state
   // ---------------------------------------------------------------
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [4:0] phase_r;
   reg [4:0] phase_nxt;
   reg dbl_r;
   reg dbl_nxt;
   reg prev_r;
   reg prev_nxt;
   reg [2:0] vote_r;
   reg [2:0] vote_nxt;
   reg [3:0] bit_cnt_r;
   reg [3:0] bit_cnt_nxt;
   reg [3:0] frame_bits_r;
   reg [3:0] frame_bits_nxt;
   reg [MAX_BITS-1:0] sr_r;
   reg [MAX_BITS-1:0] sr_nxt;
   reg [2:0] defer_r;
   reg [2:0] defer_nxt;
   reg push_r;
   reg push_nxt;
   reg push_fe_r;
   reg push_fe_nxt;
   reg [MAX_BITS-1:0] push_data_r;
   reg [MAX_BITS-1:0] push_data_nxt;
   reg decide;
   reg voted;
   reg [4:0] first;
   reg [4:0] last;

   wire fifo_in_ready;
   wire [MAX_BITS:0] fifo_out;

   always @* begin
      state_nxt = state_r;
      phase_nxt = phase_r;
      dbl_nxt = dbl_r;
      prev_nxt = prev_r;
      vote_nxt = vote_r;
      bit_cnt_nxt = bit_cnt_r;
      frame_bits_nxt = frame_bits_r;
      sr_nxt = sr_r;
      defer_nxt = defer_r;
      push_nxt = 1'b0;
      push_fe_nxt = push_fe_r;
      push_data_nxt = push_data_r;
      first = vote_first(dbl_r);
      last = first + `UAR_VOTE_SPAN;
      decide = 1'b0;
      voted = 1'b0;
      // all sampling waits for the oversample tick
      if (i_os_tick) begin
         prev_nxt = rx_sync_r;
         if (state_r == ST_IDLE) begin
            // falling step on an idle-high line is sample 1
            if (prev_r && !rx_sync_r) begin
               state_nxt = ST_START;
               phase_nxt = 5'h01;
               // mode held for the whole frame
               dbl_nxt = i_double_speed_sel;
               frame_bits_nxt = i_frame_bits;
               bit_cnt_nxt = `UAR_BITCNT_RST;
               vote_nxt = `UAR_VOTE_RST;
            end
         end else if (state_r == ST_DEFER) begin
            defer_nxt = defer_r - 3'h1;
            if (defer_r == 3'h1) begin
               state_nxt = ST_IDLE;
            end
         end else begin
            // phase wraps after 16 or 8 samples
            if (phase_r == spb(dbl_r)) begin
               phase_nxt = 5'h01;
            end else begin
               phase_nxt = phase_r + 5'h01;
            end
            if ((phase_nxt >= first) && (phase_nxt <= last)) begin
               vote_nxt = {vote_r[1:0], rx_sync_r};
            end
            decide = (phase_nxt == last);
            // two of three decide the level
            voted = maj3({vote_r[1:0], rx_sync_r});
         end
         if (decide) begin
            case (state_r)
               ST_START: begin
                  // high majority means a noise spike
                  if (voted) begin
                     state_nxt = ST_IDLE;
                     phase_nxt = `UAR_PHASE_RST;
                  end else begin
                     // timing now aligned to this start
                     state_nxt = ST_DATA;
                  end
               end
               ST_DATA: begin
                  sr_nxt = {voted, sr_r[MAX_BITS-1:1]};
                  bit_cnt_nxt = bit_cnt_r + 4'h1;
                  // after the last data or parity bit only one stop bit
                  if (bit_cnt_nxt == frame_bits_r) begin
                     state_nxt = ST_STOP;
                  end
               end
               ST_STOP: begin
                  push_nxt = 1'b1;
                  // zero stop bit marks a framing error
                  push_fe_nxt = ~voted;
                  // lsb-first shifting leaves short frames at the top
                  push_data_nxt = sr_r >> (MAX_BITS - frame_bits_r);
                  phase_nxt = `UAR_PHASE_RST;
                  if (dbl_r) begin
                     // double speed holds off the next start a while
                     state_nxt = ST_DEFER;
                     defer_nxt = `UAR_DBL_DEFER;
                  end else begin
                     // next edge may come on the very next sample
                     state_nxt = ST_IDLE;
                  end
               end
               default: begin
                  state_nxt = ST_IDLE;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         state_r <= ST_IDLE;
         phase_r <= `UAR_PHASE_RST;
         dbl_r <= 1'b0;
         prev_r <= 1'b1;
         vote_r <= `UAR_VOTE_RST;
         bit_cnt_r <= `UAR_BITCNT_RST;
         frame_bits_r <= `UAR_FRAME_BITS_MAX;
         sr_r <= {MAX_BITS{1'b0}};
         defer_r <= 3'h0;
         push_r <= 1'b0;
         push_fe_r <= 1'b0;
         push_data_r <= {MAX_BITS{1'b0}};
         o_rx_overrun <= 1'b0;
         o_rx_busy <= 1'b0;
      end else begin
         state_r <= state_nxt;
         phase_r <= phase_nxt;
         dbl_r <= dbl_nxt;
         prev_r <= prev_nxt;
         vote_r <= vote_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         frame_bits_r <= frame_bits_nxt;
         sr_r <= sr_nxt;
         defer_r <= defer_nxt;
         push_r <= push_nxt;
         push_fe_r <= push_fe_nxt;
         push_data_r <= push_data_nxt;
         // a serial source cannot be stalled, so a full fifo drops the frame
         o_rx_overrun <= push_r & ~fifo_in_ready;
         o_rx_busy <= (state_nxt != ST_IDLE);
      end
   end

   // ---------------------------------------------------------------
   // frame fifo
   // ---------------------------------------------------------------
   // error mark stored beside its frame
   uar_fifo #(
      .WIDTH(MAX_BITS + 1),
      .DEPTH(FIFO_DEPTH),
      .CNT_W(FIFO_CNT_W)
   ) u_fifo (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_in_valid(push_r),
      .i_in_data({push_fe_r, push_data_r}),
      .o_in_ready(fifo_in_ready),
      .o_out_valid(o_rx_valid),
      .o_out_data(fifo_out),
      .i_out_ready(i_rx_ready)
   );

   assign o_rx_data = fifo_out[MAX_BITS-1:0];
   assign o_frame_error_flag = fifo_out[MAX_BITS];

endmodule

// ===== bench/uar_tx_model.sv
// remote asynchronous transmitter driving the receive line
`timescale 1ns/1ps
module uar_tx_model (
   input wire i_core_clk,
   input wire i_os_tick,
   output logic o_line
);
   initial o_line = 1'b1;
   // wait n oversample ticks, then step off the edge
   task automatic tk(input int n);
      repeat (n) begin
         @(posedge i_core_clk);
         while (i_os_tick !== 1'b1) @(posedge i_core_clk);
      end
      #1;
   endtask
   task automatic send(input [9:0] d, input int nb, spb, input stp, input int slen);
      o_line = 1'b0;
      tk(spb);
      for (int i = 0; i < nb; i++) begin
         o_line = d[i];
         tk(spb);
      end
      o_line = stp;
      tk(slen);
      o_line = 1'b1;
   endtask
   task automatic spike(input int n);
      o_line = 1'b0;
      tk(n);
      o_line = 1'b1;
   endtask
endmodule

// ===== bench/uar_rx_recovery_properties.sv
// assertions on the ports of the receive recovery block
`timescale 1ns/1ps
module uar_rx_recovery_properties #(
   parameter MAX_BITS = 10,
   parameter FIFO_DEPTH = 4,
   parameter FIFO_CNT_W = 3
) (
   input wire i_core_clk,
   input wire i_sys_rst,
   input wire i_rx_serial_in,
   input wire i_os_tick,
   input wire i_double_speed_sel,
   input wire [3:0] i_frame_bits,
   input wire i_rx_ready,
   input wire o_rx_valid,
   input wire [MAX_BITS-1:0] o_rx_data,
   input wire o_frame_error_flag,
   input wire o_rx_overrun,
   input wire o_rx_busy
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   // ticks while busy; a frame never needs more than twelve bit times
   logic [8:0] busy_ticks_r;
   always @(posedge i_core_clk) begin
      if (i_sys_rst || !o_rx_busy) busy_ticks_r <= 9'h000;
      else if (i_os_tick && busy_ticks_r != 9'h1FF) busy_ticks_r <= busy_ticks_r + 9'h001;
   end
   sequence s_start;
      $rose(o_rx_busy);
   endsequence
   sequence s_qualify;
      o_rx_busy [*8];
   endsequence
   a_start_cause: assert property (
      s_start |-> $past(i_os_tick) && !$past(i_rx_serial_in, 3)) else $error("start without low tick");
   a_qual_hold: assert property (
      s_start |-> s_qualify) else $error("start dropped before vote");
   a_busy_bound: assert property (
      busy_ticks_r <= 9'h0BE) else $error("receiver busy too long");
   a_valid_cause: assert property (
      $rose(o_rx_valid) |-> $past(o_rx_busy, 4)) else $error("frame without reception");
   a_head_stable: assert property (
      o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data) && $stable(o_frame_error_flag))
      else $error("head changed while unread");
   a_ovr_full: assert property (
      o_rx_overrun |-> o_rx_valid) else $error("overrun with empty buffer");
   a_ovr_pulse: assert property (
      o_rx_overrun |=> !o_rx_overrun) else $error("overrun longer than one cycle");
   a_reset_quiet: assert property (
      $fell(i_sys_rst) |-> !o_rx_valid && !o_rx_busy && !o_rx_overrun && o_rx_data == '0)
      else $error("outputs active after reset");
endmodule
bind uar_rx_recovery uar_rx_recovery_properties #(.MAX_BITS(MAX_BITS),
   .FIFO_DEPTH(FIFO_DEPTH), .FIFO_CNT_W(FIFO_CNT_W)) uar_rx_recovery_properties_i (
   .i_core_clk, .i_sys_rst, .i_rx_serial_in, .i_os_tick, .i_double_speed_sel,
   .i_frame_bits, .i_rx_ready, .o_rx_valid, .o_rx_data, .o_frame_error_flag,
   .o_rx_overrun, .o_rx_busy);

// ===== bench/uar_rx_recovery_tb_top.sv
// self-checking bench for the receive recovery block
`timescale 1ns/1ps
module uar_rx_recovery_tb_top;
   logic clk, rst, tick, dbl, rdy;
   logic [3:0] fb;
   logic [1:0] div;
   logic [15:0] rnd;
   wire line, vld, fe, ovr, busy;
   wire [9:0] dat;
   int n_fail = 0, total_checks = 0, ov_cnt = 0;
   logic [10:0] expq[$];
   uar_rx_recovery uar_rx_recovery_i (.i_core_clk(clk), .i_sys_rst(rst),
      .i_rx_serial_in(line), .i_os_tick(tick), .i_double_speed_sel(dbl),
      .i_frame_bits(fb), .i_rx_ready(rdy), .o_rx_valid(vld), .o_rx_data(dat),
      .o_frame_error_flag(fe), .o_rx_overrun(ovr), .o_rx_busy(busy));
   uar_tx_model uar_tx_model_i (.i_core_clk(clk), .i_os_tick(tick), .o_line(line));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // tick every fourth clock, as a baud generator would
   always @(posedge clk) begin
      #1;
      div = div + 2'h1;
      tick = (div == 2'h3);
   end
   always @(posedge clk) if (ovr === 1'b1) ov_cnt++;
   function automatic logic [15:0] lfsr(input [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // error mark above the frame bits, unused bits zero
   function automatic logic [10:0] expect_of(input [9:0] d, input [3:0] nb, input stp);
      return {~stp, d & ((10'h001 << nb) - 10'h001)};
   endfunction
   task automatic chk(input [15:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic frame(input d2, input [3:0] nb, input stp, input int slen, input push);
      rnd = lfsr(rnd);
      dbl = d2;
      fb = nb;
      if (push) expq.push_back(expect_of(rnd[9:0], nb, stp));
      uar_tx_model_i.send(rnd[9:0], nb, d2 ? 8 : 16, stp, slen);
   endtask
   task automatic drain(input int n);
      int w;
      logic [10:0] e;
      repeat (n) begin
         w = 0;
         while (vld !== 1'b1 && w < 400) begin
            @(posedge clk);
            #1;
            w++;
         end
         e = expq.pop_front();
         chk({4'h0, vld, fe, dat}, {4'h1, e});
         rdy = 1'b1;
         @(posedge clk);
         #1;
         rdy = 1'b0;
         repeat (2) @(posedge clk);
         #1;
      end
   endtask
   // ----
   // scenarios
   // ----
   initial begin
      logic [3:0] nb;
      rst = 1'b1;
      tick = 1'b0;
      dbl = 1'b0;
      rdy = 1'b0;
      fb = 4'h8;
      div = 2'h0;
      rnd = 16'hC93C;
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      uar_tx_model_i.tk(20);
      // every length in both modes, some stop bits low
      for (int i = 0; i < 12; i++) begin
         nb = 4'h5 + 4'(i / 2);
         frame(i[0], nb, i % 3 != 2, i[0] ? 8 : 16, 1);
         drain(1);
         uar_tx_model_i.tk(2);
      end
      // short and boundary noise spikes are rejected
      dbl = 1'b0;
      uar_tx_model_i.spike(3);
      uar_tx_model_i.tk(20);
      uar_tx_model_i.spike(8);
      uar_tx_model_i.tk(20);
      chk({14'h0000, busy, vld}, 16'h0000);
      // next start right after the stop vote, then one frame too many
      for (int i = 0; i < 5; i++) frame(1'b0, 4'h8, 1'b1, i < 4 ? 10 : 16, i < 4);
      uar_tx_model_i.tk(4);
      chk(16'(ov_cnt), 16'h0001);
      drain(4);
      // double speed back to back with full stop
      repeat (2) frame(1'b1, 4'hA, 1'b1, 8, 1);
      drain(2);
      stop_test();
   end
   initial begin
      #1_500_000;
      n_fail++;
      stop_test();
   end
endmodule
